// File: verilog/sbrg_top.sv
`timescale 1ns/1ps
`include "sbrg_map.svh"

module sbrg_top
  import sbrg_pkg::*;
#(
  parameter int DIV_W = 8, // width of the baud timer and divisor
  parameter int PRE_W = 6  // width of the oversample prescaler
) (
  input  wire logic         sys_clk,          // system clock, 100 MHz
  input  wire logic         rstn,             // synchronous reset, active low
  input  wire logic [7:0]   reg_addr,         // register address
  input  wire logic [7:0]   reg_wdata,        // register write data
  input  wire logic         reg_wr,           // write strobe
  input  wire logic         reg_rd,           // read strobe
  output logic      [7:0]   reg_rdata,        // read data, cycle after strobe
  input  wire logic         receive_data_pin, // raw receive pin
  input  wire sbrg_status_t shifter_status,   // status from the shifters
  output sbrg_ctl_t         ctl,              // control to the shifters
  output sbrg_mode_t        mode,             // decoded generator mode
  output logic              master_clock,     // shift clock made here
  output logic              sample_tick,      // one pulse per timer period
  output logic              bit_tick,         // one pulse per bit time
  output logic              rx_level          // voted receive level
);

  // software visible state

  logic [DIV_W-1:0] baud_divisor;
  logic [7:0]       transmit_status_control;
  logic [7:0]       receive_status_control;

  // timer state

  logic [DIV_W-1:0] baud_timer;
  logic [PRE_W-1:0] prescale;
  logic [PRE_W-1:0] prescale_last;
  logic             timer_done;
  logic             rate_active;
  logic             pre_wrap;

  // decoded strobes

  logic wr_div;
  logic wr_xmt;
  logic wr_rcv;
  logic rd_div;
  logic rd_xmt;
  logic rd_rcv;

  logic [7:0] next_rdata;

  // one address compare, shared by every strobe decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  // strobe decode
  assign wr_div = reg_wr & hit(reg_addr, `SBRG_ADDR_DIV);
  assign wr_xmt = reg_wr & hit(reg_addr, `SBRG_ADDR_XMT);
  assign wr_rcv = reg_wr & hit(reg_addr, `SBRG_ADDR_RCV);
  assign rd_div = reg_rd & hit(reg_addr, `SBRG_ADDR_DIV);
  assign rd_xmt = reg_rd & hit(reg_addr, `SBRG_ADDR_XMT);
  assign rd_rcv = reg_rd & hit(reg_addr, `SBRG_ADDR_RCV);

  // divisor register

  // any value 0..255 is kept as written, none is clamped
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      baud_divisor <= DIV_W'(`SBRG_RST_DIV);
    end else if (wr_div) begin
      baud_divisor <= reg_wdata[DIV_W-1:0];
    end
  end

  // transmit status and control register

  // bit 3 is unimplemented and bit 1 belongs to the transmit shifter,
  // so neither is stored here
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      transmit_status_control <= `SBRG_RST_XMT & 8'hf5;
    end else if (wr_xmt) begin
      transmit_status_control <= reg_wdata & 8'hf5;
    end
  end

  // receive status and control register

  // only the upper five bits are writable; the error and ninth bits
  // are live status from the receiver
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      receive_status_control <= `SBRG_RST_RCV;
    end else if (wr_rcv) begin
      // a software write wins over the receiver's end-of-reception clear
      receive_status_control <= reg_wdata & 8'hf8;
    end else if (shifter_status.single_rx_done) begin
      receive_status_control[`SBRG_RCV_SREN] <= 1'b0;
    end
  end

  // control fields to the shifters

  // all fields come straight from register flip-flops
  always_comb begin
    ctl.serial_enable       = receive_status_control[`SBRG_RCV_SPEN];
    ctl.rx_nine             = receive_status_control[`SBRG_RCV_RX9];
    ctl.single_rx           = receive_status_control[`SBRG_RCV_SREN];
    ctl.cont_rx             = receive_status_control[`SBRG_RCV_CREN];
    ctl.addr_detect         = receive_status_control[`SBRG_RCV_ADDEN];
    ctl.clock_source_select = transmit_status_control[`SBRG_XMT_CLOCK_SOURCE_SELECT];
    ctl.tx_nine             = transmit_status_control[`SBRG_XMT_TX9];
    ctl.tx_enable           = transmit_status_control[`SBRG_XMT_TXEN];
    ctl.sync_mode           = transmit_status_control[`SBRG_XMT_SYNC];
    ctl.high_speed_select   = transmit_status_control[`SBRG_XMT_HS];
    ctl.tx_ninth_bit        = transmit_status_control[`SBRG_XMT_TX9D];
  end

  // mode decode

  // mode select picks the family; within it either the speed bit or
  // the clock source bit picks the variant
  always_comb begin
    if (ctl.sync_mode) begin
      if (ctl.clock_source_select) begin
        mode = SBRG_SYNC_MASTER;
      end else begin
        mode = SBRG_SYNC_SLAVE;
      end
    end else if (ctl.high_speed_select) begin
      mode = SBRG_ASYNC_HI;
    end else begin
      mode = SBRG_ASYNC_LO;
    end
  end

  // the speed bit never reaches the synchronous branches above
  always_comb begin
    case (mode)
      SBRG_ASYNC_LO:    prescale_last = PRE_W'(`SBRG_PRE_LO);
      SBRG_ASYNC_HI:    prescale_last = PRE_W'(`SBRG_PRE_HI);
      SBRG_SYNC_MASTER: prescale_last = PRE_W'(`SBRG_PRE_SYNC);
      SBRG_SYNC_SLAVE:  prescale_last = PRE_W'(`SBRG_PRE_SYNC);
      default:          prescale_last = PRE_W'(`SBRG_PRE_LO);
    endcase
  end

  // in slave mode the shift clock is external, so no bit ticks leave
  assign rate_active  = (mode != SBRG_SYNC_SLAVE);
  assign master_clock = (mode == SBRG_SYNC_MASTER);

  // baud timer

  // a down counter: reaching zero ends one period of divisor+1 cycles
  assign timer_done = (baud_timer == '0);

  // the timer never stops; a divisor write reloads it with the new
  // value that same edge instead of waiting out the old period
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      baud_timer <= DIV_W'(`SBRG_RST_DIV);
    end else if (wr_div) begin
      baud_timer <= reg_wdata[DIV_W-1:0];
    end else if (timer_done) begin
      baud_timer <= baud_divisor;
    end else begin
      baud_timer <= baud_timer - 1'b1;
    end
  end

  // oversample prescaler

  // >= rather than == so a mode change to a shorter ratio cannot
  // leave the count above its new end and run on for 64 ticks
  assign pre_wrap = (prescale >= prescale_last);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prescale <= '0;
    end else if (wr_div) begin
      prescale <= '0;
    end else if (timer_done) begin
      if (pre_wrap) begin
        prescale <= '0;
      end else begin
        prescale <= prescale + 1'b1;
      end
    end
  end

  // tick outputs

  // registered, so both ticks lag the timer by one cycle but are glitch free
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= timer_done & ~wr_div;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= timer_done & pre_wrap & rate_active & ~wr_div;
    end
  end

  // receive line sampling

  // samples are taken on the oversample tick, three in a row
  sbrg_vote u_vote (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .pin       (receive_data_pin),
    .sample_en (sample_tick),
    .level     (rx_level)
  );

  // register read port

  // unmapped addresses read as zero; reads have no side effects
  always_comb begin
    next_rdata = 8'h00;
    if (rd_div) begin
      next_rdata = 8'(baud_divisor);
    end else if (rd_xmt) begin
      next_rdata = transmit_status_control;
      next_rdata[`SBRG_XMT_TRMT] = shifter_status.tx_shift_empty;
    end else if (rd_rcv) begin
      next_rdata = receive_status_control;
      next_rdata[`SBRG_RCV_FERR] = shifter_status.framing_err;
      next_rdata[`SBRG_RCV_OERR] = shifter_status.overrun_err;
      next_rdata[`SBRG_RCV_RX9D] = shifter_status.rx_ninth_bit;
    end
  end

  // data valid only in the cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// File: verilog/sbrg_map.svh
// Contract
// - one dedicated 8-bit baud timer serves asynchronous and synchronous operation
// - the timer runs freely; its period is set by the 8-bit divisor register
// - asynchronous low speed: bit rate is clock / (64 * (divisor + 1))
// - asynchronous high speed: bit rate is clock / (16 * (divisor + 1))
// - synchronous: bit rate is clock / (4 * (divisor + 1))
// - in synchronous mode the high-speed select has no effect
// - in synchronous mode the generated rate is used only as clock master; slave clock comes from outside
// - every divisor 0 through 255 is accepted and gives its own period
// - writing the divisor restarts the timer at once with the new value
// - the receive pin is sampled three times and resolved by majority vote
// - synchronous mode: clock source set means master, cleared means slave
// - asynchronous generator output runs at 16 or 64 times the bit rate
// - mode select set means synchronous, cleared means asynchronous
`ifndef SBRG_MAP_SVH
`define SBRG_MAP_SVH

// register offsets on the plain register port
`define SBRG_ADDR_RCV      8'h18
`define SBRG_ADDR_XMT      8'h98
`define SBRG_ADDR_DIV      8'h99

// reset values
`define SBRG_RST_RCV       8'h00
`define SBRG_RST_XMT       8'h02
`define SBRG_RST_DIV       8'h00

// transmit status and control field positions
`define SBRG_XMT_CLOCK_SOURCE_SELECT      7
`define SBRG_XMT_TX9       6
`define SBRG_XMT_TXEN      5
`define SBRG_XMT_SYNC      4
`define SBRG_XMT_HS        2
`define SBRG_XMT_TRMT      1
`define SBRG_XMT_TX9D      0

// receive status and control field positions
`define SBRG_RCV_SPEN      7
`define SBRG_RCV_RX9       6
`define SBRG_RCV_SREN      5
`define SBRG_RCV_CREN      4
`define SBRG_RCV_ADDEN     3
`define SBRG_RCV_FERR      2
`define SBRG_RCV_OERR      1
`define SBRG_RCV_RX9D      0

// oversample ticks per bit, minus one
`define SBRG_PRE_LO        6'd63
`define SBRG_PRE_HI        6'd15
`define SBRG_PRE_SYNC      6'd3

`endif

// File: verilog/sbrg_pkg.sv
package sbrg_pkg;

  // operating mode of the generator
  typedef enum logic [1:0] {
    SBRG_ASYNC_LO    = 2'b00,
    SBRG_ASYNC_HI    = 2'b01,
    SBRG_SYNC_MASTER = 2'b10,
    SBRG_SYNC_SLAVE  = 2'b11
  } sbrg_mode_t;

  // control bits handed to the shifters
  typedef struct packed {
    logic serial_enable;
    logic rx_nine;
    logic single_rx;
    logic cont_rx;
    logic addr_detect;
    logic clock_source_select;
    logic tx_nine;
    logic tx_enable;
    logic sync_mode;
    logic high_speed_select;
    logic tx_ninth_bit;
  } sbrg_ctl_t;

  // status bits coming back from the shifters
  typedef struct packed {
    logic tx_shift_empty;
    logic framing_err;
    logic overrun_err;
    logic rx_ninth_bit;
    logic single_rx_done;
  } sbrg_status_t;

endpackage

// File: verilog/sbrg_vote.sv
`timescale 1ns/1ps
module sbrg_vote (
  input  wire logic sys_clk,   // system clock
  input  wire logic rstn,      // synchronous reset, active low
  input  wire logic pin,       // raw receive pin
  input  wire logic sample_en, // take one sample this cycle
  output logic      level      // voted line level
);

  logic       sync_a;
  logic       sync_b;
  logic [2:0] samples;

  // two-stage synchroniser; idle line is high
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
    end
  end

  // keep the last three samples
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      samples <= 3'h7;
    end else if (sample_en) begin
      samples <= {samples[1:0], sync_b};
    end
  end

  // two of three decides, so a single glitch sample is ignored
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      level <= 1'b1;
    end else begin
      level <= (samples[0] & samples[1]) | (samples[0] & samples[2])
             | (samples[1] & samples[2]);
    end
  end

endmodule

// File: verification/sbrg_sva.sv
`timescale 1ns/1ps
`include "sbrg_map.svh"
module sbrg_sva
  import sbrg_pkg::*;
#(
  parameter int DIV_W = 8, // divisor width
  parameter int PRE_W = 6  // prescaler width
) (
  input wire logic         sys_clk,          // clock
  input wire logic         rstn,             // reset, active low
  input wire logic [7:0]   reg_addr,         // address
  input wire logic [7:0]   reg_wdata,        // write data
  input wire logic         reg_wr,           // write strobe
  input wire logic         reg_rd,           // read strobe
  input wire logic [7:0]   reg_rdata,        // read data
  input wire logic         receive_data_pin, // raw pin
  input wire sbrg_status_t shifter_status,   // shifter status
  input wire sbrg_ctl_t    ctl,              // control out
  input wire sbrg_mode_t   mode,             // mode out
  input wire logic         master_clock,     // master flag
  input wire logic         sample_tick,      // timer tick
  input wire logic         bit_tick,         // bit tick
  input wire logic         rx_level          // voted level
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [DIV_W-1:0] div_q;  // divisor as written
  logic [8:0]       ph;     // cycles since restart or tick
  logic [15:0]      cyc;    // cycles since bit tick
  logic             ok;     // last interval undisturbed
  sbrg_mode_t       mode_q; // mode one cycle ago
  logic [15:0]      n_exp;  // expected bit period
  logic             div_wr; // divisor write this cycle
  assign div_wr = reg_wr && reg_addr == `SBRG_ADDR_DIV;
  // divisor shadow
  always_ff @(posedge sys_clk) begin
    if (!rstn) div_q <= '0;
    else if (div_wr) div_q <= reg_wdata;
  end
  // reset behaves like a write of zero, so one phase counter serves both
  always_ff @(posedge sys_clk) begin
    if (!rstn || div_wr) ph <= 9'h000;
    else if (sample_tick) ph <= 9'h001;
    else ph <= ph + 9'h001;
  end
  // first bit interval after a write or mode change is not judged
  always_ff @(posedge sys_clk) begin
    mode_q <= mode;
    cyc <= bit_tick ? 16'h0001 : cyc + 16'h0001;
    if (!rstn || div_wr || mode != mode_q) ok <= 1'b0;
    else if (bit_tick) ok <= 1'b1;
  end
  assign n_exp = (mode == SBRG_ASYNC_LO ? 16'h0040 : mode == SBRG_ASYNC_HI ? 16'h0010 :
                  16'h0004) * (16'(div_q) + 16'h0001);
  sequence s_div_rd;
    reg_rd && reg_addr == `SBRG_ADDR_DIV;
  endsequence
  sequence s_xmt_wr;
    reg_wr && reg_addr == `SBRG_ADDR_XMT;
  endsequence
  a_tick_phase: assert property (sample_tick == (ph == 9'(div_q) + 9'h001))
    else $error("sample tick off its period");
  a_bit_period: assert property (bit_tick && ok && mode == mode_q |-> cyc == n_exp)
    else $error("bit period wrong");
  a_bit_late: assert property (ok && mode == mode_q && mode != SBRG_SYNC_SLAVE |-> cyc <= n_exp)
    else $error("bit tick overdue");
  a_mode_map: assert property (
    mode == (ctl.sync_mode ? {1'b1, !ctl.clock_source_select} : {1'b0, ctl.high_speed_select}))
    else $error("mode decode wrong");
  a_master_map: assert property (master_clock == (mode == SBRG_SYNC_MASTER))
    else $error("master clock flag wrong");
  a_slave_quiet: assert property (
    mode == SBRG_SYNC_SLAVE && $past(mode) == SBRG_SYNC_SLAVE |-> !bit_tick)
    else $error("bit tick in slave mode");
  a_vote_lag: assert property (
    $changed(rx_level) |-> rx_level == $past(receive_data_pin, 3) ||
    rx_level == $past(receive_data_pin, 4))
    else $error("voted level without pin cause");
  a_xmt_fields: assert property (
    s_xmt_wr |=> ctl[5:0] == {$past(reg_wdata[7:4]), $past(reg_wdata[2]), $past(reg_wdata[0])})
    else $error("transmit control not stored");
  a_div_back: assert property (s_div_rd |=> reg_rdata == div_q)
    else $error("divisor read back wrong");
endmodule
bind sbrg_top sbrg_sva #(.DIV_W(DIV_W), .PRE_W(PRE_W)) i_sva (
  .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .receive_data_pin(receive_data_pin), .shifter_status(shifter_status), .ctl(ctl),
  .mode(mode), .master_clock(master_clock), .sample_tick(sample_tick),
  .bit_tick(bit_tick), .rx_level(rx_level));

// File: verification/sbrg_shifter_model.sv
`timescale 1ns/1ps
module sbrg_shifter_model
  import sbrg_pkg::*;
(
  input  wire logic       sys_clk,  // clock
  input  wire logic       rstn,     // reset, active low
  input  wire sbrg_ctl_t  ctl,      // control in
  input  wire sbrg_mode_t mode,     // generator mode
  input  wire logic       bit_tick, // bit pulse
  input  wire logic [2:0] inj_err,  // framing, overrun, ninth bit
  output sbrg_status_t    status    // status back
);
  logic [3:0] bits; // bits of this single receive
  logic       done; // single receive finished
  // shifts only on internal bit ticks; a slave clock would come from outside
  always_ff @(posedge sys_clk) begin
    if (!rstn || !ctl.single_rx) begin
      bits <= 4'h0;
      done <= 1'b0;
    end else begin
      done <= bit_tick && bits == 4'h7 && mode == SBRG_SYNC_MASTER;
      if (bit_tick && mode == SBRG_SYNC_MASTER)
        bits <= bits + 4'h1;
    end
  end
  // shift register counts as empty while the transmitter is off
  assign status = {~ctl.tx_enable, inj_err, done};
endmodule

// File: verification/tb_sbrg_top.sv
`timescale 1ns/1ps
`include "sbrg_map.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin failures++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module tb_sbrg_top;
  import sbrg_pkg::*;
  logic         sys_clk, rstn, reg_wr, reg_rd, receive_data_pin;
  logic         master_clock, sample_tick, bit_tick, rx_level;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata, rv;
  logic [2:0]   inj_err;
  sbrg_status_t shifter_status;
  sbrg_ctl_t    ctl;
  sbrg_mode_t   mode;
  int           failures, compares, n;
  // high speed also used for the slowest rate
  logic [7:0]   xm [6] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h90, 8'h94};
  int           dv [6] = '{0, 2, 0, 255, 3, 3};
  int           nn [6] = '{64, 64, 16, 16, 4, 4};
  sbrg_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .receive_data_pin(receive_data_pin), .shifter_status(shifter_status), .ctl(ctl),
    .mode(mode), .master_clock(master_clock), .sample_tick(sample_tick),
    .bit_tick(bit_tick), .rx_level(rx_level));
  sbrg_shifter_model i_far (.sys_clk(sys_clk), .rstn(rstn), .ctl(ctl), .mode(mode),
    .bit_tick(bit_tick), .inj_err(inj_err), .status(shifter_status));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task conclude;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function logic sig(input int sel);
    return sel ? bit_tick === 1'b1 : sample_tick === 1'b1;
  endfunction
  // counts edges up to the next tick; n is the distance
  task wait_hi(input int sel, input int lim);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (!sig(sel) && n < lim);
    if (!sig(sel)) begin
      failures++;
      $display("Error tick wait expected 1 seen 0");
      conclude();
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  task wait_lvl(input logic v);
    n = 0;
    while (rx_level !== v && n < 12) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    `CHK("voted level", v, rx_level)
    if (rx_level !== v) conclude();
  endtask
  task t_regs;
    rd(`SBRG_ADDR_RCV);
    `CHK("rcv reset", `SBRG_RST_RCV, rv)
    rd(`SBRG_ADDR_XMT);
    `CHK("xmt reset", `SBRG_RST_XMT, rv)
    rd(`SBRG_ADDR_DIV);
    `CHK("div reset", `SBRG_RST_DIV, rv)
    wr(8'h19, 8'hff);
    rd(8'h19);
    `CHK("unmapped", 8'h00, rv)
    wr(`SBRG_ADDR_DIV, 8'hff);
    rd(`SBRG_ADDR_DIV);
    `CHK("div max", 8'hff, rv)
    wr(`SBRG_ADDR_XMT, 8'hff);
    rd(`SBRG_ADDR_XMT);
    `CHK("xmt stored", 8'hf5, rv)
    `CHK("mode master", SBRG_SYNC_MASTER, mode)
    wr(`SBRG_ADDR_XMT, 8'h00);
    wr(`SBRG_ADDR_RCV, 8'hf8);
    rd(`SBRG_ADDR_RCV);
    `CHK("rcv ctl", 5'h1f, ctl[10:6])
    wr(`SBRG_ADDR_RCV, 8'h00);
  endtask
  task t_rates;
    for (int i = 0; i < 6; i++) begin
      wr(`SBRG_ADDR_XMT, xm[i]);
      wr(`SBRG_ADDR_DIV, 8'(dv[i]));
      wait_hi(0, 300);
      wait_hi(0, 300);
      `CHK("sample period", dv[i] + 1, n)
      wait_hi(1, 20000);
      wait_hi(1, 20000);
      `CHK("bit period", nn[i] * (dv[i] + 1), n)
      `CHK("master clock", xm[i][7], master_clock)
    end
  endtask
  // a long old period must not delay the new one
  task t_restart;
    wr(`SBRG_ADDR_XMT, 8'h04);
    wr(`SBRG_ADDR_DIV, 8'hc8);
    repeat (50) @(posedge sys_clk);
    wr(`SBRG_ADDR_DIV, 8'h01);
    wait_hi(0, 300);
    `CHK("restart delay", 2, n)
    wait_hi(0, 300);
    `CHK("new period", 2, n)
  endtask
  task t_slave;
    wr(`SBRG_ADDR_XMT, 8'h14);
    n = 0;
    repeat (300) begin
      @(posedge sys_clk);
      #1;
      if (bit_tick !== 1'b0) n++;
    end
    `CHK("slave ticks", 0, n)
    `CHK("slave mode", SBRG_SYNC_SLAVE, mode)
    `CHK("slave clock", 1'b0, master_clock)
  endtask
  // one low sample among highs must lose the vote
  task t_vote;
    wr(`SBRG_ADDR_XMT, 8'h04);
    wr(`SBRG_ADDR_DIV, 8'h00);
    @(posedge sys_clk);
    receive_data_pin <= 1'b0;
    @(posedge sys_clk);
    receive_data_pin <= 1'b1;
    n = 0;
    repeat (10) begin
      @(posedge sys_clk);
      #1;
      if (rx_level !== 1'b1) n++;
    end
    `CHK("glitch", 0, n)
    @(posedge sys_clk);
    receive_data_pin <= 1'b0;
    wait_lvl(1'b0);
    @(posedge sys_clk);
    receive_data_pin <= 1'b1;
    wait_lvl(1'b1);
  endtask
  task t_single;
    @(posedge sys_clk);
    inj_err <= 3'b101;
    wr(`SBRG_ADDR_XMT, 8'h90);
    wr(`SBRG_ADDR_DIV, 8'h00);
    wr(`SBRG_ADDR_RCV, 8'ha0);
    rd(`SBRG_ADDR_RCV);
    `CHK("rcv live", 8'ha5, rv)
    repeat (8) wait_hi(1, 100);
    repeat (3) @(posedge sys_clk);
    rd(`SBRG_ADDR_RCV);
    `CHK("single cleared", 8'h85, rv)
    @(posedge sys_clk);
    inj_err <= 3'b000;
  endtask
  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    receive_data_pin = 1'b1;
    inj_err = 3'b000;
    failures = 0;
    compares = 0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs();
    t_rates();
    t_restart();
    t_slave();
    t_vote();
    t_single();
    conclude();
  end
endmodule
